// *** hw/cspm_pkg.sv ***
// constants for the status-word and mode/privilege block
// assumes one cpu clock domain; shared by all design files
package cspm_pkg;
  localparam int CSPM_WORD_W = 32;
  // status word field positions
  localparam int CSPM_NEG_BIT = 31;
  localparam int CSPM_ZERO_BIT = 30;
  localparam int CSPM_CARRY_BIT = 29;
  localparam int CSPM_OVF_BIT = 28;
  localparam int CSPM_SAT_BIT = 27;
  localparam int CSPM_ICIT_HI_MSB = 26;
  localparam int CSPM_ICIT_HI_LSB = 25;
  localparam int CSPM_ISTATE_BIT = 24;
  localparam int CSPM_LANE_MSB = 19;
  localparam int CSPM_LANE_LSB = 16;
  localparam int CSPM_ICIT_LO_MSB = 15;
  localparam int CSPM_ICIT_LO_LSB = 10;
  localparam int CSPM_EXC_W_BIG = 9;
  localparam int CSPM_EXC_W_SMALL = 6;
  // reset value of the execution state register
  localparam logic [31:0] CSPM_EXEC_RESET = 32'h0100_0000;
  // control register bits
  localparam int CSPM_CTRL_NPRIV_BIT = 0;
  localparam int CSPM_CTRL_SPSEL_BIT = 1;
  localparam logic [1:0] CSPM_CTRL_RESET = 2'h0;
  // exception numbers
  localparam logic [8:0] CSPM_EXC_THREAD = 9'h000;
  localparam logic [8:0] CSPM_EXC_NMI = 9'h002;
  localparam logic [8:0] CSPM_EXC_HARD = 9'h003;
  localparam logic [8:0] CSPM_EXC_MEMMAN = 9'h004;
  localparam logic [8:0] CSPM_EXC_BUS = 9'h005;
  localparam logic [8:0] CSPM_EXC_USAGE = 9'h006;
  localparam logic [8:0] CSPM_EXC_SVC = 9'h00b;
  localparam logic [8:0] CSPM_EXC_PENDABLE_SERVICE_EXCEPTION = 9'h00e;
  localparam logic [8:0] CSPM_EXC_TICK = 9'h00f;
  localparam logic [8:0] CSPM_EXC_IRQ0 = 9'h010;
  localparam logic [8:0] CSPM_EXC_MAX_BIG = 9'h0ff;
  localparam logic [8:0] CSPM_EXC_MAX_SMALL = 9'h02f;
  // special register selectors for move instructions
  localparam logic [1:0] CSPM_SEL_APP = 2'h0;
  localparam logic [1:0] CSPM_SEL_PSW = 2'h1;
  localparam logic [1:0] CSPM_SEL_CTRL = 2'h2;
  localparam logic [1:0] CSPM_SEL_EXC = 2'h3;
  typedef enum logic [0:0] {
    CSPM_THREAD = 1'b0,
    CSPM_HANDLER = 1'b1
  } cspm_mode_t;
endpackage : cspm_pkg

// *** hw/cspm_exc_check.sv ***
// checks an exception number against the legal set of the chosen variant
// assumes the number is already zero-extended to nine bits
`timescale 1ns/100ps
module cspm_exc_check
  import cspm_pkg::*;
#(
  parameter bit BIG = 1'b1
) (
  input wire logic [8:0] num,
  output logic legal
);
  always_comb begin
    legal = 1'b0;
    if (num >= CSPM_EXC_IRQ0) begin
      legal = BIG ? 1'b1 : (num <= CSPM_EXC_MAX_SMALL);
    end else begin
      unique case (num)
        CSPM_EXC_NMI, CSPM_EXC_HARD, CSPM_EXC_SVC, CSPM_EXC_PENDABLE_SERVICE_EXCEPTION, CSPM_EXC_TICK: legal = 1'b1;
        CSPM_EXC_MEMMAN, CSPM_EXC_BUS, CSPM_EXC_USAGE: legal = BIG;
        default: legal = 1'b0;
      endcase
    end
  end
endmodule : cspm_exc_check

// *** hw/cspm_psw_mask.sv ***
// builds the writable/readable bit mask of the status word per variant
// purely combinational, constant for a given variant
`timescale 1ns/100ps
module cspm_psw_mask
  import cspm_pkg::*;
#(
  parameter bit BIG = 1'b1
) (
  output logic [31:0] app_mask,
  output logic [31:0] exec_mask,
  output logic [31:0] exc_mask
);
  always_comb begin
    app_mask = 32'h0;
    exec_mask = 32'h0;
    exc_mask = 32'h0;
    app_mask[CSPM_NEG_BIT:CSPM_OVF_BIT] = 4'hf;
    exec_mask[CSPM_ISTATE_BIT] = 1'b1;
    if (BIG) begin
      app_mask[CSPM_SAT_BIT] = 1'b1;
      app_mask[CSPM_LANE_MSB:CSPM_LANE_LSB] = 4'hf;
      exec_mask[CSPM_ICIT_HI_MSB:CSPM_ICIT_HI_LSB] = 2'h3;
      exec_mask[CSPM_ICIT_LO_MSB:CSPM_ICIT_LO_LSB] = 6'h3f;
      exc_mask[CSPM_EXC_W_BIG-1:0] = 9'h1ff;
    end else begin
      exc_mask[CSPM_EXC_W_SMALL-1:0] = 6'h3f;
    end
  end
endmodule : cspm_psw_mask

// *** hw/cspm_core.sv ***
// status word, operating mode, privilege and stack select of one cpu core
// assumes the execute stage drives result flags and the exception sequencer
// drives entry/return pulses on the same clock; all inputs are synchronous
`timescale 1ns/100ps

// Summary of operation
// RL1: flags negative, zero, carry, overflow at bits 31..28 follow instruction results.
// RL2: big variant keeps sticky saturation flag at bit 27; small variant reserves 27..25.
// RL3: big variant keeps continuation state at bits 26..25 and 15..10.
// RL4: bit 24 is instruction-set state; executing while it is zero raises hard fault.
// RL5: big variant keeps four lane compare flags at bits 19..16.
// RL6: big variant exception number is 9 bits, thread 0, IRQ numbers up to 255; the check accepts every number from 16 up to 511.
// RL7: small variant exception number is bits 5..0, up to 47; bits 23..6 reserved.
// RL8: processor leaves reset in thread mode.
// RL9: handler mode while servicing; thread again only when no exception remains active.
// RL10: unprivileged code is denied mask instructions, system blocks and some special moves.
// RL11: privileged code may use every instruction and resource.
// RL12: thread privilege follows control bit; handler mode is always privileged.
// RL13: only privileged writes can change the privilege bit of the control register.
// RL14: supervisor call enters a privileged handler from unprivileged code.
// RL15: handler mode always uses the main stack pointer.
// RL16: exception entry and return update control and may switch stack pointer.
// RL17: software follows a stack select change with an instruction sync barrier.
// RL18: control bit 1 selects main (0, reset) or process (1) stack in thread mode.
// RL19: execution state resets to 0x0100_0000 with bit 24 from reset vector bit 0.
// RL20: reserved status bits read zero and ignore writes.
module cspm_core
  import cspm_pkg::*;
#(
  parameter bit BIG = 1'b1,
  parameter int NEST_W = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // reset vector bit 0, sampled at the first enabled edge after reset with RESET_VEC_VALID high
  input wire logic RESET_VEC_BIT0,
  input wire logic RESET_VEC_VALID,
  // flag updates from the execute stage
  input wire logic FLAG_WE,
  input wire logic [3:0] FLAG_NZCV,
  input wire logic SAT_SET,
  input wire logic LANE_WE,
  input wire logic [3:0] LANE_FLAGS,
  input wire logic CONT_WE,
  input wire logic [7:0] CONT_STATE,
  // an instruction is about to issue
  input wire logic INSTR_ISSUE,
  input wire logic [2:0] INSTR_CLASS,
  // special register moves
  input wire logic MOVE_WE,
  input wire logic [1:0] MOVE_SEL,
  input wire logic [31:0] MOVE_WDATA,
  input wire logic [1:0] MOVE_RSEL,
  output logic [31:0] MOVE_RDATA,
  // exception sequencer
  input wire logic EXC_ENTRY,
  input wire logic [8:0] EXC_NUM,
  input wire logic EXC_RETURN,
  input wire logic [8:0] EXC_RET_NUM,
  input wire logic EXC_RET_TO_THREAD,
  input wire logic EXC_RET_USE_PSP,
  // status outputs
  output logic [31:0] PSW,
  output logic HANDLER_MODE,
  output logic PRIVILEGED,
  output logic USE_PSP,
  output logic [1:0] CONTROL,
  output logic INSTR_DENIED,
  output logic HARD_FAULT_REQ,
  output logic EXC_NUM_ERR
);
  // instruction classes that the privilege check needs
  localparam logic [2:0] CLS_PLAIN = 3'h0;
  localparam logic [2:0] CLS_IRQ_MASK = 3'h1;
  localparam logic [2:0] CLS_SYS_ACCESS = 3'h2;
  localparam logic [2:0] CLS_SPECIAL_MOVE = 3'h3;
  localparam logic [2:0] CLS_SVC = 3'h4;

  // refused at elaboration: the nesting counter needs at least two bits
  if (NEST_W < 2 || NEST_W > 16) begin : g_bad_nest_w
    $error("cspm_core: NEST_W must lie between 2 and 16");
  end

  logic [3:0] nzcv;
  logic sat;
  logic [3:0] lane;
  logic [1:0] cont_hi;
  logic [5:0] cont_lo;
  logic istate;
  logic istate_loaded;
  logic [8:0] exc_num;
  cspm_mode_t mode;
  logic [NEST_W-1:0] nest;
  logic ctrl_npriv;
  logic ctrl_spsel;
  logic [31:0] app_mask;
  logic [31:0] exec_mask;
  logic [31:0] exc_mask;
  logic entry_legal;
  logic priv_now;
  logic [31:0] psw_raw;
  logic [31:0] next_rdata;
  logic next_denied;
  logic last_return;

  cspm_psw_mask #(.BIG(BIG)) u_mask (
    .app_mask(app_mask),
    .exec_mask(exec_mask),
    .exc_mask(exc_mask)
  );

  cspm_exc_check #(.BIG(BIG)) u_check (
    .num(EXC_NUM),
    .legal(entry_legal)
  );

  // handler mode is privileged whatever the control bit holds
  assign priv_now = (mode == CSPM_HANDLER) || !ctrl_npriv; // [RL12] [RL11]
  assign last_return = EXC_RETURN && (nest == NEST_W'(1));

  always_comb begin
    psw_raw = 32'h0;
    psw_raw[CSPM_NEG_BIT:CSPM_OVF_BIT] = nzcv; // [RL1]
    psw_raw[CSPM_SAT_BIT] = sat; // [RL2]
    psw_raw[CSPM_ICIT_HI_MSB:CSPM_ICIT_HI_LSB] = cont_hi; // [RL3]
    psw_raw[CSPM_ISTATE_BIT] = istate; // [RL4]
    psw_raw[CSPM_LANE_MSB:CSPM_LANE_LSB] = lane; // [RL5]
    psw_raw[CSPM_ICIT_LO_MSB:CSPM_ICIT_LO_LSB] = cont_lo;
    psw_raw[8:0] = exc_num; // [RL6] [RL7]
  end

  // applicative flags, with the variant's mask hiding absent fields
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      nzcv <= 4'h0;
    end else if (CE) begin
      if (FLAG_WE) begin
        nzcv <= FLAG_NZCV; // [RL1]
      end else if (MOVE_WE && MOVE_SEL == CSPM_SEL_APP) begin
        nzcv <= MOVE_WDATA[CSPM_NEG_BIT:CSPM_OVF_BIT];
      end
    end
  end

  // saturation is sticky: hardware set beats a software clear in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sat <= 1'b0;
    end else if (CE && BIG) begin
      if (SAT_SET) begin
        sat <= 1'b1; // [RL2]
      end else if (MOVE_WE && MOVE_SEL == CSPM_SEL_APP) begin
        sat <= MOVE_WDATA[CSPM_SAT_BIT];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lane <= 4'h0;
    end else if (CE && BIG) begin
      if (LANE_WE) begin
        lane <= LANE_FLAGS; // [RL5]
      end else if (MOVE_WE && MOVE_SEL == CSPM_SEL_APP) begin
        lane <= MOVE_WDATA[CSPM_LANE_MSB:CSPM_LANE_LSB];
      end
    end
  end

  // continuation state is cleared on exception entry after the sequencer stacks it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cont_hi <= 2'h0;
      cont_lo <= 6'h0;
    end else if (CE && BIG) begin
      if (CONT_WE) begin
        cont_hi <= CONT_STATE[7:6]; // [RL3]
        cont_lo <= CONT_STATE[5:0];
      end else if (EXC_ENTRY) begin
        cont_hi <= 2'h0;
        cont_lo <= 6'h0;
      end
    end
  end

  // instruction-set bit: reset constant, then caught from the vector once
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      istate <= CSPM_EXEC_RESET[CSPM_ISTATE_BIT]; // [RL19]
      istate_loaded <= 1'b0;
    end else if (CE && !istate_loaded && RESET_VEC_VALID) begin
      istate <= RESET_VEC_BIT0; // [RL19]
      istate_loaded <= 1'b1;
    end
  end

  // issuing with the state bit clear is a hard fault
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HARD_FAULT_REQ <= 1'b0;
    end else if (CE) begin
      HARD_FAULT_REQ <= INSTR_ISSUE && !istate; // [RL4]
    end
  end

  // nesting depth: thread mode is re-entered only on a return taken at depth one
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      nest <= '0;
    end else if (CE) begin
      if (EXC_ENTRY && entry_legal && !EXC_RETURN) begin
        if (nest != '1) begin
          nest <= nest + NEST_W'(1);
        end
      end else if (EXC_RETURN && !EXC_ENTRY && nest != '0) begin
        nest <= nest - NEST_W'(1); // [RL9]
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode <= CSPM_THREAD; // [RL8]
    end else if (CE) begin
      if (EXC_ENTRY && entry_legal) begin
        mode <= CSPM_HANDLER; // [RL9] [RL14]
      end else if (last_return && EXC_RET_TO_THREAD) begin
        mode <= CSPM_THREAD; // [RL9]
      end
    end
  end

  // active exception number follows entry and return
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      exc_num <= CSPM_EXC_THREAD;
    end else if (CE) begin
      if (EXC_ENTRY && entry_legal) begin
        exc_num <= EXC_NUM & exc_mask[8:0]; // [RL6] [RL7]
      end else if (last_return && EXC_RET_TO_THREAD) begin
        exc_num <= CSPM_EXC_THREAD;
      end else if (EXC_RETURN) begin
        exc_num <= EXC_RET_NUM & exc_mask[8:0];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      EXC_NUM_ERR <= 1'b0;
    end else if (CE) begin
      EXC_NUM_ERR <= EXC_ENTRY && !entry_legal;
    end
  end

  // privilege bit: only privileged moves may change it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_npriv <= CSPM_CTRL_RESET[CSPM_CTRL_NPRIV_BIT];
    end else if (CE) begin
      if (MOVE_WE && MOVE_SEL == CSPM_SEL_CTRL && priv_now) begin
        ctrl_npriv <= MOVE_WDATA[CSPM_CTRL_NPRIV_BIT]; // [RL13]
      end
    end
  end

  // stack select: entry forces main, the last return to thread restores the caller's choice
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_spsel <= CSPM_CTRL_RESET[CSPM_CTRL_SPSEL_BIT]; // [RL18]
    end else if (CE) begin
      if (EXC_ENTRY && entry_legal) begin
        ctrl_spsel <= 1'b0; // [RL16] [RL15]
      end else if (last_return && EXC_RET_TO_THREAD) begin
        ctrl_spsel <= EXC_RET_USE_PSP; // [RL16]
      end else if (MOVE_WE && MOVE_SEL == CSPM_SEL_CTRL && mode == CSPM_THREAD && priv_now) begin
        // the new pointer is used from the next cycle; software fences with a barrier
        ctrl_spsel <= MOVE_WDATA[CSPM_CTRL_SPSEL_BIT]; // [RL18] [RL17]
      end
    end
  end

  // privilege check of each issued instruction
  always_comb begin
    next_denied = 1'b0;
    if (INSTR_ISSUE && !priv_now) begin
      unique case (INSTR_CLASS)
        CLS_IRQ_MASK, CLS_SYS_ACCESS: next_denied = 1'b1; // [RL10]
        CLS_SPECIAL_MOVE: next_denied = (MOVE_SEL == CSPM_SEL_CTRL) || MOVE_WE; // [RL10]
        CLS_PLAIN, CLS_SVC: next_denied = 1'b0; // [RL14]
        default: next_denied = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      INSTR_DENIED <= 1'b0;
    end else if (CE) begin
      INSTR_DENIED <= next_denied; // [RL10] [RL11]
    end
  end

  // read path: reserved bits are masked to zero
  always_comb begin
    next_rdata = 32'h0;
    unique case (MOVE_RSEL)
      CSPM_SEL_APP: next_rdata = psw_raw & app_mask; // [RL20]
      CSPM_SEL_PSW: next_rdata = psw_raw & (app_mask | exec_mask | exc_mask); // [RL20]
      CSPM_SEL_CTRL: next_rdata = {30'h0, ctrl_spsel, ctrl_npriv};
      CSPM_SEL_EXC: next_rdata = psw_raw & exc_mask;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MOVE_RDATA <= 32'h0;
      PSW <= CSPM_EXEC_RESET;
    end else if (CE) begin
      MOVE_RDATA <= next_rdata;
      PSW <= psw_raw & (app_mask | exec_mask | exc_mask);
    end
  end

  assign HANDLER_MODE = (mode == CSPM_HANDLER);
  assign PRIVILEGED = priv_now;
  assign USE_PSP = (mode == CSPM_THREAD) && ctrl_spsel; // [RL15] [RL18]
  assign CONTROL = {ctrl_spsel, ctrl_npriv};
endmodule : cspm_core

// *** bench/cspm_core_properties.sv ***
// concurrent checks on the mode, privilege and status outputs of cspm_core
// assumes one clock domain; bound to every cspm_core instance below
`timescale 1ns/100ps
module cspm_core_props
  import cspm_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic FLAG_WE,
  input wire logic [3:0] FLAG_NZCV,
  input wire logic INSTR_ISSUE,
  input wire logic [2:0] INSTR_CLASS,
  input wire logic EXC_ENTRY,
  input wire logic [8:0] EXC_NUM,
  input wire logic [31:0] PSW,
  input wire logic HANDLER_MODE,
  input wire logic PRIVILEGED,
  input wire logic USE_PSP,
  input wire logic [1:0] CONTROL,
  input wire logic INSTR_DENIED,
  input wire logic EXC_NUM_ERR
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // two quiet edges make the check blind to whether flags land in one or two cycles
  sequence s_flag_load;
    CE && FLAG_WE ##1 !FLAG_WE ##1 !FLAG_WE;
  endsequence
  sequence s_svc_entry;
    CE && EXC_ENTRY && EXC_NUM == CSPM_EXC_SVC;
  endsequence
  property p_flag_load;
    s_flag_load |-> PSW[31:28] == $past(FLAG_NZCV, 2);
  endproperty
  a_flag_load: assert property (p_flag_load) else $error("flag nibble not loaded");
  property p_svc_entry;
    s_svc_entry |=> HANDLER_MODE && PRIVILEGED && !USE_PSP;
  endproperty
  a_svc_entry: assert property (p_svc_entry) else $error("entry did not reach privileged handler");
  property p_handler_priv;
    HANDLER_MODE |-> PRIVILEGED;
  endproperty
  a_handler_priv: assert property (p_handler_priv) else $error("handler mode unprivileged");
  property p_thread_priv;
    !HANDLER_MODE |-> PRIVILEGED == !CONTROL[0];
  endproperty
  a_thread_priv: assert property (p_thread_priv) else $error("thread privilege not from control");
  property p_handler_msp;
    HANDLER_MODE |-> !USE_PSP;
  endproperty
  a_handler_msp: assert property (p_handler_msp) else $error("handler mode on process stack");
  property p_deny_mask;
    CE && INSTR_ISSUE && INSTR_CLASS == 3'h1 && !PRIVILEGED |=> INSTR_DENIED;
  endproperty
  a_deny_mask: assert property (p_deny_mask) else $error("masking instruction not denied");
  property p_priv_free;
    CE && INSTR_ISSUE && PRIVILEGED |=> !INSTR_DENIED;
  endproperty
  a_priv_free: assert property (p_priv_free) else $error("privileged issue denied");
  property p_bad_num;
    CE && EXC_ENTRY && EXC_NUM == 9'h001 |=> EXC_NUM_ERR && HANDLER_MODE == $past(HANDLER_MODE);
  endproperty
  a_bad_num: assert property (p_bad_num) else $error("reserved number accepted");
  property p_reset_state;
    $fell(RST) |-> !HANDLER_MODE && CONTROL == CSPM_CTRL_RESET && PSW == CSPM_EXEC_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("wrong state out of reset");
endmodule : cspm_core_props

bind cspm_core cspm_core_props i_cspm_core_props (.CLK(CLK), .RST(RST), .CE(CE), .FLAG_WE(FLAG_WE),
  .FLAG_NZCV(FLAG_NZCV), .INSTR_ISSUE(INSTR_ISSUE), .INSTR_CLASS(INSTR_CLASS), .EXC_ENTRY(EXC_ENTRY),
  .EXC_NUM(EXC_NUM), .PSW(PSW), .HANDLER_MODE(HANDLER_MODE), .PRIVILEGED(PRIVILEGED), .USE_PSP(USE_PSP),
  .CONTROL(CONTROL), .INSTR_DENIED(INSTR_DENIED), .EXC_NUM_ERR(EXC_NUM_ERR));

// *** bench/cpu_status_mode_privilege_test.sv ***
// self-checking bench for cspm_core, large variant plus a small one on the same stimulus
// assumes the props checker is compiled alongside and bound to the core
`timescale 1ns/100ps
module cpu_status_mode_privilege_test
  import cspm_pkg::*;
;
  logic CLK, RST, CE, RESET_VEC_BIT0, RESET_VEC_VALID, FLAG_WE, SAT_SET, LANE_WE, CONT_WE, INSTR_ISSUE;
  logic MOVE_WE, EXC_ENTRY, EXC_RETURN, EXC_RET_TO_THREAD, EXC_RET_USE_PSP;
  logic HANDLER_MODE, PRIVILEGED, USE_PSP, INSTR_DENIED, HARD_FAULT_REQ, EXC_NUM_ERR;
  logic [3:0] FLAG_NZCV, LANE_FLAGS;
  logic [7:0] CONT_STATE;
  logic [2:0] INSTR_CLASS;
  logic [1:0] MOVE_SEL, MOVE_RSEL, CONTROL;
  logic [31:0] MOVE_WDATA, MOVE_RDATA, PSW, MOVE_RDATA_S, PSW_S;
  logic [8:0] EXC_NUM, EXC_RET_NUM;
  int failures = 0;
  int num_checks = 0;
  logic [8:0] codes [10] = '{9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h00b, 9'h00e, 9'h00f, 9'h010, 9'h0ff};

  cspm_core #(.BIG(1'b1), .NEST_W(8)) i_cspm_core (.CLK(CLK), .RST(RST), .CE(CE),
    .RESET_VEC_BIT0(RESET_VEC_BIT0), .RESET_VEC_VALID(RESET_VEC_VALID), .FLAG_WE(FLAG_WE),
    .FLAG_NZCV(FLAG_NZCV), .SAT_SET(SAT_SET), .LANE_WE(LANE_WE), .LANE_FLAGS(LANE_FLAGS), .CONT_WE(CONT_WE),
    .CONT_STATE(CONT_STATE), .INSTR_ISSUE(INSTR_ISSUE), .INSTR_CLASS(INSTR_CLASS), .MOVE_WE(MOVE_WE),
    .MOVE_SEL(MOVE_SEL), .MOVE_WDATA(MOVE_WDATA), .MOVE_RSEL(MOVE_RSEL), .MOVE_RDATA(MOVE_RDATA),
    .EXC_ENTRY(EXC_ENTRY), .EXC_NUM(EXC_NUM), .EXC_RETURN(EXC_RETURN), .EXC_RET_NUM(EXC_RET_NUM),
    .EXC_RET_TO_THREAD(EXC_RET_TO_THREAD), .EXC_RET_USE_PSP(EXC_RET_USE_PSP), .PSW(PSW),
    .HANDLER_MODE(HANDLER_MODE), .PRIVILEGED(PRIVILEGED), .USE_PSP(USE_PSP), .CONTROL(CONTROL),
    .INSTR_DENIED(INSTR_DENIED), .HARD_FAULT_REQ(HARD_FAULT_REQ), .EXC_NUM_ERR(EXC_NUM_ERR));

  // small variant shares every input; its state drifts from the large one, so it is checked sparingly
  cspm_core #(.BIG(1'b0), .NEST_W(8)) i_cspm_core_small (.CLK(CLK), .RST(RST), .CE(CE),
    .RESET_VEC_BIT0(RESET_VEC_BIT0), .RESET_VEC_VALID(RESET_VEC_VALID), .FLAG_WE(FLAG_WE),
    .FLAG_NZCV(FLAG_NZCV), .SAT_SET(SAT_SET), .LANE_WE(LANE_WE), .LANE_FLAGS(LANE_FLAGS), .CONT_WE(CONT_WE),
    .CONT_STATE(CONT_STATE), .INSTR_ISSUE(INSTR_ISSUE), .INSTR_CLASS(INSTR_CLASS), .MOVE_WE(MOVE_WE),
    .MOVE_SEL(MOVE_SEL), .MOVE_WDATA(MOVE_WDATA), .MOVE_RSEL(MOVE_RSEL), .MOVE_RDATA(MOVE_RDATA_S),
    .EXC_ENTRY(EXC_ENTRY), .EXC_NUM(EXC_NUM), .EXC_RETURN(EXC_RETURN), .EXC_RET_NUM(EXC_RET_NUM),
    .EXC_RET_TO_THREAD(EXC_RET_TO_THREAD), .EXC_RET_USE_PSP(EXC_RET_USE_PSP), .PSW(PSW_S),
    .HANDLER_MODE(), .PRIVILEGED(), .USE_PSP(), .CONTROL(),
    .INSTR_DENIED(), .HARD_FAULT_REQ(), .EXC_NUM_ERR());

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic complete_run();
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // each strobe task leaves one edge with the strobe low before it can be raised again
  task automatic enter(input logic [8:0] n);
    @(posedge CLK);
    EXC_ENTRY <= 1'b1;
    EXC_NUM <= n;
    @(posedge CLK);
    EXC_ENTRY <= 1'b0;
    #1;
  endtask : enter

  task automatic leave(input logic [8:0] n, input logic thr, input logic process_stack_pointer);
    @(posedge CLK);
    EXC_RETURN <= 1'b1;
    EXC_RET_NUM <= n;
    EXC_RET_TO_THREAD <= thr;
    EXC_RET_USE_PSP <= process_stack_pointer;
    @(posedge CLK);
    EXC_RETURN <= 1'b0;
    #1;
  endtask : leave

  task automatic mwrite(input logic [1:0] sel, input logic [31:0] d);
    @(posedge CLK);
    MOVE_WE <= 1'b1;
    MOVE_SEL <= sel;
    MOVE_WDATA <= d;
    @(posedge CLK);
    MOVE_WE <= 1'b0;
    #1;
  endtask : mwrite

  // read data is registered: one edge to take the select, one more to be safe
  task automatic mread(input logic [1:0] sel);
    @(posedge CLK);
    MOVE_RSEL <= sel;
    repeat (2) @(posedge CLK);
    #1;
  endtask : mread

  task automatic issue(input logic [2:0] cls);
    @(posedge CLK);
    INSTR_ISSUE <= 1'b1;
    INSTR_CLASS <= cls;
    @(posedge CLK);
    INSTR_ISSUE <= 1'b0;
    #1;
  endtask : issue

  task automatic t_flags();
    @(posedge CLK);
    FLAG_WE <= 1'b1;
    FLAG_NZCV <= 4'ha;
    SAT_SET <= 1'b1;
    LANE_WE <= 1'b1;
    LANE_FLAGS <= 4'h5;
    CONT_WE <= 1'b1;
    CONT_STATE <= 8'hc5;
    @(posedge CLK);
    FLAG_WE <= 1'b0;
    SAT_SET <= 1'b0;
    LANE_WE <= 1'b0;
    CONT_WE <= 1'b0;
    repeat (2) @(posedge CLK);
    #1;
    chk("nzcv", 32'ha, 32'(PSW[31:28]));
    chk("sat", 32'h1, 32'(PSW[27]));
    chk("cont", 32'hc5, 32'({PSW[26:25], PSW[15:10]}));
    chk("lanes", 32'h5, 32'(PSW[19:16]));
    chk("small_psw", 32'ha100_0000, PSW_S);
    mwrite(CSPM_SEL_APP, 32'hffff_ffff);
    repeat (2) @(posedge CLK);
    #1;
    chk("nzcv_move", 32'hf, 32'(PSW[31:28]));
    chk("reserved", 32'h0, 32'({PSW[23:20], PSW[9]}));
    mread(CSPM_SEL_APP);
    chk("rd_app", 32'hf80f_0000, MOVE_RDATA);
    mread(CSPM_SEL_PSW);
    chk("rd_psw", 32'hff0f_1400, MOVE_RDATA);
    chk("rd_psw_small", 32'hf100_0000, MOVE_RDATA_S);
  endtask : t_flags

  task automatic t_exc();
    foreach (codes[i]) begin
      enter(codes[i]);
      @(posedge CLK);
      #1;
      chk("num", 32'(codes[i]), 32'(PSW[8:0]));
      chk("num_small", (codes[i] <= CSPM_EXC_MAX_SMALL && (codes[i] < 9'h004 || codes[i] > 9'h006)) ?
        32'(codes[i]) : 32'h0, 32'(PSW_S[8:0]));
      leave(CSPM_EXC_THREAD, 1'b1, 1'b0);
    end
    enter(CSPM_EXC_SVC);
    enter(CSPM_EXC_MAX_BIG);
    leave(CSPM_EXC_SVC, 1'b0, 1'b0);
    @(posedge CLK);
    #1;
    chk("mode_nested", 32'h1, 32'(HANDLER_MODE));
    chk("num_resumed", 32'h00b, 32'(PSW[8:0]));
    mread(CSPM_SEL_EXC);
    chk("rd_exc", 32'h00b, MOVE_RDATA);
    chk("rd_exc_small", 32'h00b, MOVE_RDATA_S);
    leave(CSPM_EXC_THREAD, 1'b1, 1'b1);
    chk("mode_thread", 32'h0, 32'(HANDLER_MODE));
    chk("psp_thread", 32'h1, 32'(USE_PSP));
    enter(9'h001);
    chk("bad_num", 32'h1, 32'(EXC_NUM_ERR));
    chk("bad_mode", 32'h0, 32'(HANDLER_MODE));
  endtask : t_exc

  task automatic t_priv();
    mwrite(CSPM_SEL_CTRL, 32'h0);
    // one barrier cycle before anything relies on the new stack pointer
    @(posedge CLK);
    #1;
    chk("msp_sel", 32'h0, 32'(USE_PSP));
    mwrite(CSPM_SEL_CTRL, 32'h3);
    chk("priv_off", 32'h0, 32'(PRIVILEGED));
    issue(3'h1);
    chk("deny_mask", 32'h1, 32'(INSTR_DENIED));
    issue(3'h2);
    chk("deny_sys", 32'h1, 32'(INSTR_DENIED));
    mwrite(CSPM_SEL_CTRL, 32'h2);
    chk("ctrl_kept", 32'h3, 32'(CONTROL));
    mread(CSPM_SEL_CTRL);
    chk("rd_ctrl", 32'h3, MOVE_RDATA);
    issue(3'h3);
    chk("deny_move", 32'h1, 32'(INSTR_DENIED));
    issue(3'h4);
    chk("svc_ok", 32'h0, 32'(INSTR_DENIED));
    enter(CSPM_EXC_SVC);
    chk("priv_handler", 32'h1, 32'(PRIVILEGED));
    chk("msp_handler", 32'h0, 32'(USE_PSP));
    issue(3'h1);
    chk("allow_mask", 32'h0, 32'(INSTR_DENIED));
    leave(CSPM_EXC_THREAD, 1'b1, 1'b1);
    chk("priv_back", 32'h0, 32'(PRIVILEGED));
    // with the enable low an entry strobe must leave the mode untouched
    @(posedge CLK);
    CE <= 1'b0;
    enter(CSPM_EXC_SVC);
    chk("ce_frozen", 32'h0, 32'(HANDLER_MODE));
    @(posedge CLK);
    CE <= 1'b1;
  endtask : t_priv

  // a second reset with a bad vector bit must leave the core faulting on issue
  task automatic t_tbit();
    @(posedge CLK);
    RST <= 1'b1;
    RESET_VEC_BIT0 <= 1'b0;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk("ctrl_reset", 32'h0, 32'(CONTROL));
    chk("istate_zero", 32'h0, 32'(PSW[24]));
    issue(3'h0);
    chk("hard_fault", 32'h1, 32'(HARD_FAULT_REQ));
  endtask : t_tbit

  initial begin
    {RST, CE, RESET_VEC_BIT0, RESET_VEC_VALID} = 4'hf;
    {FLAG_WE, SAT_SET, LANE_WE, CONT_WE, INSTR_ISSUE, MOVE_WE} = 6'h00;
    {EXC_ENTRY, EXC_RETURN, EXC_RET_TO_THREAD, EXC_RET_USE_PSP} = 4'h0;
    {FLAG_NZCV, LANE_FLAGS, CONT_STATE, INSTR_CLASS} = 19'h00000;
    {MOVE_SEL, MOVE_RSEL, MOVE_WDATA, EXC_NUM, EXC_RET_NUM} = 54'h0;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    repeat (2) @(posedge CLK);
    #1;
    chk("psw_reset", CSPM_EXEC_RESET, PSW);
    chk("mode_reset", 32'h0, 32'(HANDLER_MODE));
    t_flags();
    t_exc();
    t_priv();
    t_tbit();
    complete_run();
  end

  initial begin
    #5000;
    failures++;
    complete_run();
  end
endmodule : cpu_status_mode_privilege_test
